// ==== pkg/cte_pkg.sv ====
package cte_pkg;

    // ------------------------------------------------------------
    // Instruction encodings (10-bit program words)
    // ------------------------------------------------------------
    localparam logic [9:0] OP_LOAD_TIMER_CTRL6   = 10'h213;
    localparam logic [9:0] OP_LOAD_WORD_POINTER  = 10'h00C;
    localparam logic [9:0] OP_WATCHDOG_TEST_CLR  = 10'h2A0;
    localparam logic [5:0] OP_EXCHANGE_PREFIX    = 6'h2D;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_INSTR    = 8'h00;
    localparam logic [7:0] ADDR_ACC      = 8'h04;
    localparam logic [7:0] ADDR_PTRS     = 8'h08;
    localparam logic [7:0] ADDR_TIMER6   = 8'h0C;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;
    localparam logic [7:0] ADDR_WDSET    = 8'h14;
    localparam logic [7:0] ADDR_MEM_BASE = 8'h40;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         PTR_Y_LSB     = 0;
    localparam int         PTR_X_LSB     = 4;
    localparam int         PTR_Z_LSB     = 8;
    localparam int         ST_WDF_BIT    = 0;
    localparam int         ST_SKIP_BIT   = 1;
    localparam int         ST_CY_BIT     = 2;
    localparam logic [3:0] NIB_RESET     = 4'h0;
    localparam logic [1:0] AXI_OKAY      = 2'h0;
    localparam logic [1:0] AXI_SLVERR    = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CTE_IDLE = 2'h1,
        CTE_RESP = 2'h2
    } cte_bus_e;

    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] ptrX;
        logic [3:0] ptrY;
        logic [1:0] ptrZ;
        logic [3:0] timerCtrlSix;
        logic       wdFlag;
        logic       skipPend;
        logic       carry;
    } cte_core_s;

endpackage

// ==== core/cte_exec.sv ====
`timescale 1ns/100ps
module cte_exec (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cte_pkg::cte_core_s core_reg,  core_next;
    logic [3:0]         mem_reg   [64];
    logic               memWe;
    logic [5:0]         memAddr;
    logic [3:0]         memWdata;
    logic [5:0]         dataPtr;
    cte_pkg::cte_bus_e  wst_reg,   wst_next;
    cte_pkg::cte_bus_e  rst_reg,   rst_next;
    logic               awHave_reg, awHave_next;
    logic               wHave_reg,  wHave_next;
    logic [7:0]         awAddr_reg, awAddr_next;
    logic [31:0]        wData_reg,  wData_next;
    logic [3:0]         wStrb_reg,  wStrb_next;
    logic [1:0]         bresp_reg,  bresp_next;
    logic [31:0]        rdata_reg,  rdata_next;
    logic [1:0]         rresp_reg,  rresp_next;
    logic               awrdy_reg,  awrdy_next;
    logic               wrdy_reg,   wrdy_next;
    logic               arrdy_reg,  arrdy_next;
    logic               doWrite;
    logic [9:0]         instr;
    logic               isExch;

    assign dataPtr = {core_reg.ptrZ, core_reg.ptrY};
    assign s_axi_awready = awrdy_reg;
    assign s_axi_wready  = wrdy_reg;
    assign s_axi_arready = arrdy_reg;
    assign s_axi_bvalid  = wst_reg[1];
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rst_reg[1];
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    always_comb begin
        wst_next    = wst_reg;
        awHave_next = awHave_reg;
        wHave_next  = wHave_reg;
        awAddr_next = awAddr_reg;
        wData_next  = wData_reg;
        wStrb_next  = wStrb_reg;
        bresp_next  = bresp_reg;
        doWrite     = 1'b0;
        if (s_axi_awvalid && awrdy_reg) begin
            awHave_next = 1'b1;
            awAddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wrdy_reg) begin
            wHave_next = 1'b1;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        case (wst_reg)
            cte_pkg::CTE_IDLE: begin
                if (awHave_reg && wHave_reg) begin
                    doWrite     = 1'b1;
                    awHave_next = 1'b0;
                    wHave_next  = 1'b0;
                    bresp_next  = (awAddr_reg[1:0] == 2'h0) ? cte_pkg::AXI_OKAY
                                                            : cte_pkg::AXI_SLVERR;
                    wst_next    = cte_pkg::CTE_RESP;
                end
            end
            cte_pkg::CTE_RESP: begin
                if (s_axi_bready) begin
                    wst_next = cte_pkg::CTE_IDLE;
                end
            end
            default: wst_next = cte_pkg::CTE_IDLE;
        endcase
        awrdy_next = !awHave_next && (wst_next == cte_pkg::CTE_IDLE);
        wrdy_next  = !wHave_next && (wst_next == cte_pkg::CTE_IDLE);
    end

    // ------------------------------------------------------------
    // Instruction execution
    // ------------------------------------------------------------
    assign instr  = wData_reg[9:0];
    assign isExch = (instr[9:4] == cte_pkg::OP_EXCHANGE_PREFIX);

    always_comb begin
        core_next = core_reg;
        memWe     = 1'b0;
        memAddr   = awAddr_reg[7:2] - 6'h10;
        memWdata  = wData_reg[3:0];
        if (doWrite && wStrb_reg[0] && awAddr_reg[1:0] == 2'h0) begin
            if (awAddr_reg == cte_pkg::ADDR_INSTR) begin
                if (core_reg.skipPend) begin
                    core_next.skipPend = 1'b0;
                end else if (instr == cte_pkg::OP_LOAD_TIMER_CTRL6) begin
                    core_next.timerCtrlSix = core_reg.acc;
                end else if (instr == cte_pkg::OP_LOAD_WORD_POINTER) begin
                    core_next.ptrY = core_reg.acc;
                end else if (instr == cte_pkg::OP_WATCHDOG_TEST_CLR) begin
                    if (core_reg.wdFlag) begin
                        core_next.skipPend = 1'b1;
                        core_next.wdFlag   = 1'b0;
                    end
                end else if (isExch) begin
                    memWe     = 1'b1;
                    memAddr   = dataPtr;
                    memWdata  = core_reg.acc;
                    core_next.acc  = mem_reg[dataPtr];
                    core_next.ptrX = core_reg.ptrX ^ instr[3:0];
                end
            end else if (awAddr_reg == cte_pkg::ADDR_ACC) begin
                core_next.acc = wData_reg[3:0];
            end else if (awAddr_reg == cte_pkg::ADDR_PTRS) begin
                core_next.ptrY = wData_reg[cte_pkg::PTR_Y_LSB +: 4];
                core_next.ptrX = wData_reg[cte_pkg::PTR_X_LSB +: 4];
                core_next.ptrZ = wData_reg[cte_pkg::PTR_Z_LSB +: 2];
            end else if (awAddr_reg == cte_pkg::ADDR_STATUS) begin
                core_next.carry = wData_reg[cte_pkg::ST_CY_BIT];
            end else if (awAddr_reg == cte_pkg::ADDR_WDSET) begin
                core_next.wdFlag = wData_reg[cte_pkg::ST_WDF_BIT];
            end else if (awAddr_reg >= cte_pkg::ADDR_MEM_BASE) begin
                memWe = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_comb begin
        rst_next   = rst_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        case (rst_reg)
            cte_pkg::CTE_IDLE: begin
                if (s_axi_arvalid && arrdy_reg) begin
                    rst_next   = cte_pkg::CTE_RESP;
                    rresp_next = cte_pkg::AXI_OKAY;
                    rdata_next = 32'h0;
                    if (s_axi_araddr >= cte_pkg::ADDR_MEM_BASE) begin
                        rdata_next[3:0] = mem_reg[s_axi_araddr[7:2] - 6'h10];
                    end else begin
                        case (s_axi_araddr)
                            cte_pkg::ADDR_ACC:    rdata_next[3:0] = core_reg.acc;
                            cte_pkg::ADDR_PTRS: begin
                                rdata_next[cte_pkg::PTR_Y_LSB +: 4] = core_reg.ptrY;
                                rdata_next[cte_pkg::PTR_X_LSB +: 4] = core_reg.ptrX;
                                rdata_next[cte_pkg::PTR_Z_LSB +: 2] = core_reg.ptrZ;
                            end
                            cte_pkg::ADDR_TIMER6: rdata_next[3:0] = core_reg.timerCtrlSix;
                            cte_pkg::ADDR_STATUS: begin
                                rdata_next[cte_pkg::ST_WDF_BIT]  = core_reg.wdFlag;
                                rdata_next[cte_pkg::ST_SKIP_BIT] = core_reg.skipPend;
                                rdata_next[cte_pkg::ST_CY_BIT]   = core_reg.carry;
                            end
                            cte_pkg::ADDR_INSTR, cte_pkg::ADDR_WDSET: rdata_next = 32'h0;
                            default: rresp_next = cte_pkg::AXI_SLVERR;
                        endcase
                    end
                end
            end
            cte_pkg::CTE_RESP: begin
                if (s_axi_rready) begin
                    rst_next = cte_pkg::CTE_IDLE;
                end
            end
            default: rst_next = cte_pkg::CTE_IDLE;
        endcase
        arrdy_next = (rst_next == cte_pkg::CTE_IDLE);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            core_reg   <= '0;
            wst_reg    <= cte_pkg::CTE_IDLE;
            rst_reg    <= cte_pkg::CTE_IDLE;
            awHave_reg <= 1'b0;
            wHave_reg  <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg  <= 32'h0;
            wStrb_reg  <= 4'h0;
            bresp_reg  <= cte_pkg::AXI_OKAY;
            rdata_reg  <= 32'h0;
            rresp_reg  <= cte_pkg::AXI_OKAY;
            awrdy_reg  <= 1'b0;
            wrdy_reg   <= 1'b0;
            arrdy_reg  <= 1'b0;
        end else begin
            core_reg   <= core_next;
            wst_reg    <= wst_next;
            rst_reg    <= rst_next;
            awHave_reg <= awHave_next;
            wHave_reg  <= wHave_next;
            awAddr_reg <= awAddr_next;
            wData_reg  <= wData_next;
            wStrb_reg  <= wStrb_next;
            bresp_reg  <= bresp_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
            awrdy_reg  <= awrdy_next;
            wrdy_reg   <= wrdy_next;
            arrdy_reg  <= arrdy_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (memWe) begin
            mem_reg[memAddr] <= memWdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic execNow;
    assign execNow = doWrite && wStrb_reg[0] && awAddr_reg == cte_pkg::ADDR_INSTR
                     && !core_reg.skipPend;

    chk_timer_load: assert property (@(posedge clk_sys) disable iff (!nrst)
        execNow && instr == cte_pkg::OP_LOAD_TIMER_CTRL6
        |=> core_reg.timerCtrlSix == $past(core_reg.acc))
        else $error("timer control six not loaded");
    chk_word_ptr: assert property (@(posedge clk_sys) disable iff (!nrst)
        execNow && instr == cte_pkg::OP_LOAD_WORD_POINTER
        |=> core_reg.ptrY == $past(core_reg.acc) && $stable(core_reg.acc))
        else $error("word pointer load wrong");
    chk_wd_skip: assert property (@(posedge clk_sys) disable iff (!nrst)
        execNow && instr == cte_pkg::OP_WATCHDOG_TEST_CLR && core_reg.wdFlag
        |=> core_reg.skipPend && !core_reg.wdFlag)
        else $error("watchdog skip or clear missing");
    chk_wd_noskip: assert property (@(posedge clk_sys) disable iff (!nrst)
        execNow && instr == cte_pkg::OP_WATCHDOG_TEST_CLR && !core_reg.wdFlag
        |=> !core_reg.skipPend)
        else $error("spurious skip");
    chk_exch_acc: assert property (@(posedge clk_sys) disable iff (!nrst)
        execNow && isExch |=> core_reg.acc == $past(mem_reg[dataPtr])
        && mem_reg[$past(dataPtr)] == $past(core_reg.acc))
        else $error("exchange swap wrong");
    chk_exch_xor: assert property (@(posedge clk_sys) disable iff (!nrst)
        execNow && isExch |=> core_reg.ptrX == ($past(core_reg.ptrX) ^ $past(instr[3:0])))
        else $error("file pointer xor wrong");
    chk_carry_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
        execNow |=> $stable(core_reg.carry))
        else $error("carry changed by instruction");
    chk_skip_once: assert property (@(posedge clk_sys) disable iff (!nrst)
        core_reg.skipPend && doWrite && wStrb_reg[0] && awAddr_reg == cte_pkg::ADDR_INSTR
        |=> !core_reg.skipPend && $stable(core_reg.acc) && $stable(core_reg.ptrX))
        else $error("skipped instruction executed");

    cov_exch:  cover property (@(posedge clk_sys) disable iff (!nrst) execNow && isExch);
    cov_skip:  cover property (@(posedge clk_sys) disable iff (!nrst)
        core_reg.skipPend ##[1:20] !core_reg.skipPend);
    cov_timer: cover property (@(posedge clk_sys) disable iff (!nrst)
        execNow && instr == cte_pkg::OP_LOAD_TIMER_CTRL6);
    cov_word:  cover property (@(posedge clk_sys) disable iff (!nrst)
        execNow && instr == cte_pkg::OP_LOAD_WORD_POINTER);
    cov_wd:    cover property (@(posedge clk_sys) disable iff (!nrst)
        execNow && instr == cte_pkg::OP_WATCHDOG_TEST_CLR && !core_reg.wdFlag);

    chk_timer_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
        execNow && instr == cte_pkg::OP_LOAD_TIMER_CTRL6
        |=> $stable(core_reg.acc) && $stable(core_reg.ptrY))
        else $error("timer load disturbed registers");
    chk_exch_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
        execNow && isExch |=> $stable(core_reg.ptrY) && $stable(core_reg.timerCtrlSix))
        else $error("exchange disturbed registers");
    chk_wd_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
        execNow && instr == cte_pkg::OP_WATCHDOG_TEST_CLR
        |=> $stable(core_reg.acc) && $stable(core_reg.ptrX))
        else $error("watchdog test disturbed registers");
    chk_skip_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        core_reg.skipPend && !(doWrite && wStrb_reg[0] && awAddr_reg == cte_pkg::ADDR_INSTR)
        |=> core_reg.skipPend)
        else $error("pending skip lost");

endmodule

// ==== dv/tb.sv ====
`timescale 1ns/100ps
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1;
    logic        s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int          fails = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          seed = 32'h3FDA;
    logic [31:0] rd;
    logic [1:0]  rsp, wrsp;
    logic [3:0]  a, m, x, y, j;
    logic [1:0]  z;

    cte_exec uut (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    always #2.5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Bus tasks and expectations
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bit aw;
        bit w;
        aw = 0;
        w = 0;
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_sys);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        wrsp = s_axi_bresp;
    endtask

    task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        rsp = s_axi_rresp;
        chk(s_axi_rdata, exp);
    endtask

    function automatic logic [31:0] exp_ptrs(input logic [3:0] px, input logic [3:0] py,
                                             input logic [1:0] pz);
        return (32'(pz) << cte_pkg::PTR_Z_LSB) | (32'(px) << cte_pkg::PTR_X_LSB)
             | (32'(py) << cte_pkg::PTR_Y_LSB);
    endfunction

    function automatic logic [31:0] exp_st(input logic cy, input logic sk, input logic wf);
        return (32'(cy) << cte_pkg::ST_CY_BIT) | (32'(sk) << cte_pkg::ST_SKIP_BIT)
             | (32'(wf) << cte_pkg::ST_WDF_BIT);
    endfunction

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rdc(cte_pkg::ADDR_ACC, 32'h0);
        rdc(cte_pkg::ADDR_PTRS, 32'h0);
        rdc(cte_pkg::ADDR_TIMER6, 32'h0);
        rdc(cte_pkg::ADDR_STATUS, 32'h0);
        rdc(8'h20, 32'h0);
        chk(32'(rsp), 32'(cte_pkg::AXI_SLVERR));
        wr(cte_pkg::ADDR_STATUS, exp_st(1'b1, 1'b0, 1'b0));
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            a = 4'($random(seed));
            m = 4'($random(seed));
            x = 4'($random(seed));
            y = 4'($random(seed));
            z = 2'($unsigned($random(seed)) % 3);
            j = 4'(i);
            wr(cte_pkg::ADDR_PTRS, exp_ptrs(x, y, z));
            wr(cte_pkg::ADDR_MEM_BASE + {z, y, 2'b00}, 32'(m));
            wr(cte_pkg::ADDR_ACC, 32'(a));
            wr(cte_pkg::ADDR_INSTR, 32'({cte_pkg::OP_EXCHANGE_PREFIX, j}));
            rdc(cte_pkg::ADDR_ACC, 32'(m));
            rdc(cte_pkg::ADDR_MEM_BASE + {z, y, 2'b00}, 32'(a));
            rdc(cte_pkg::ADDR_PTRS, exp_ptrs(x ^ j, y, z));
            rdc(cte_pkg::ADDR_STATUS, exp_st(1'b1, 1'b0, 1'b0));
        end
        $display("test exchange done");
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($random(seed));
            wr(cte_pkg::ADDR_ACC, 32'(a));
            wr(cte_pkg::ADDR_INSTR, 32'(cte_pkg::OP_LOAD_TIMER_CTRL6));
            rdc(cte_pkg::ADDR_TIMER6, 32'(a));
            wr(cte_pkg::ADDR_INSTR, 32'(cte_pkg::OP_LOAD_WORD_POINTER));
            rdc(cte_pkg::ADDR_PTRS, exp_ptrs(x ^ j, a, z));
            rdc(cte_pkg::ADDR_ACC, 32'(a));
            rdc(cte_pkg::ADDR_STATUS, exp_st(1'b1, 1'b0, 1'b0));
        end
        $display("test transfers done");
        wr(cte_pkg::ADDR_WDSET, 32'h1);
        chk(32'(wrsp), 32'(cte_pkg::AXI_OKAY));
        rdc(cte_pkg::ADDR_STATUS, exp_st(1'b1, 1'b0, 1'b1));
        chk(32'(rsp), 32'(cte_pkg::AXI_OKAY));
        wr(cte_pkg::ADDR_INSTR, 32'(cte_pkg::OP_WATCHDOG_TEST_CLR));
        rdc(cte_pkg::ADDR_STATUS, exp_st(1'b1, 1'b1, 1'b0));
        wr(cte_pkg::ADDR_ACC, 32'(a ^ 4'hF));
        wr(cte_pkg::ADDR_INSTR, 32'(cte_pkg::OP_LOAD_TIMER_CTRL6));
        rdc(cte_pkg::ADDR_TIMER6, 32'(a));
        rdc(cte_pkg::ADDR_STATUS, exp_st(1'b1, 1'b0, 1'b0));
        wr(cte_pkg::ADDR_INSTR, 32'(cte_pkg::OP_WATCHDOG_TEST_CLR));
        rdc(cte_pkg::ADDR_STATUS, exp_st(1'b1, 1'b0, 1'b0));
        wr(cte_pkg::ADDR_INSTR, 32'(cte_pkg::OP_LOAD_TIMER_CTRL6));
        rdc(cte_pkg::ADDR_TIMER6, 32'(a ^ 4'hF));
        wr(8'h01, 32'h0);
        chk(32'(wrsp), 32'(cte_pkg::AXI_SLVERR));
        $display("test watchdog done");
        report_and_stop();
    end
endmodule
